// ### hw/cjf_params.svh
// Register map, field positions, reset values and timing counts
//
// Contract
// - Per-channel bit places attenuator in receive/transmit
// - Two-bit field: depth 16, 32 or bypass
// - FIFO written on path clock, read smoothed
// - Smoothed clock made internally, one per channel
// - Fill within two of limits sets flag
// - Reading flag resets FIFO and clears flag; a set in the same cycle wins, so the flag survives that read
// - Pattern enable sends 2^23-1 or 2^15-1
// - Pattern enable also starts receive checker
// - Checker locked drives violation output low
// - Out of lock: status bit set, output high
// - Zero-to-one insert write adds one error
// - Each detected error pulses output one period
// - Pattern mode forces single-rail format, except on transmit in remote loopback and on receive in digital loopback
// - Two bits select three loopback modes
// - Digital loopback routes transmit pins to receive
// - Remote loopback returns received data to transmit
`ifndef CJF_PARAMS_SVH
`define CJF_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses, one word per channel)
// ----------------------------------------------------------------
`define CJF_CTRL_BASE   8'h00
`define CJF_STAT_BASE   8'h40
`define CJF_CTRL_RESET  8'h00

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CJF_F_PATH      0
`define CJF_F_CFG0      1
`define CJF_F_CFG1      2
`define CJF_F_PAT_EN    3
`define CJF_F_INS       4
`define CJF_F_LB_A      5
`define CJF_F_LB_B      6
`define CJF_F_RATE_E3   7

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define CJF_S_LIMIT     0
`define CJF_S_SYNC_LOST 1
`define CJF_S_RUNNING   2

// ----------------------------------------------------------------
// Timing and thresholds
// ----------------------------------------------------------------
`define CJF_FIFO_MAX    32
`define CJF_LIMIT_GAP   2
`define CJF_CLK_LOW     2
`define CJF_SYNC_GOOD   32
`define CJF_LOSS_ERR    4
`define CJF_PRBS23_TAP  17
`define CJF_PRBS15_TAP  13

`endif

// ### hw/cjf_pkg.sv
// Types shared by the channel logic
package cjf_pkg;

	typedef struct packed {
		logic rate_e3;
		logic loop_b;
		logic loop_a;
		logic err_insert;
		logic pattern_enable;
		logic cfg_bit1;
		logic cfg_bit0;
		logic path_tx;
	} cjf_ctrl_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} cjf_rail_t;

	typedef enum logic [1:0] {
		CJF_LB_NONE,
		CJF_LB_ANALOG,
		CJF_LB_REMOTE,
		CJF_LB_DIGITAL
	} cjf_lb_t;

	typedef enum logic {
		CJF_HUNT,
		CJF_LOCK
	} cjf_chk_t;

endpackage : cjf_pkg

// ### hw/cjf_channel.sv
// Jitter attenuator FIFO, pattern generator/checker and loopbacks
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cjf_params.svh"

module cjf_channel
	import cjf_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Avalon-MM slave
	input  wire logic [7:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [3:0]            avs_byteenable,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// Framer transmit side
	input  wire logic [CHANNELS-1:0]   line_transmit_clock,
	input  wire logic [CHANNELS-1:0]   transmit_positive_data,
	input  wire logic [CHANNELS-1:0]   transmit_negative_data,
	// Framer receive side
	output logic      [CHANNELS-1:0]   line_receive_clock,
	output logic      [CHANNELS-1:0]   receive_positive_data,
	output logic      [CHANNELS-1:0]   rx_neg_violation_out,
	// Line side, toward the driver
	output logic      [CHANNELS-1:0]   tx_line_clock,
	output logic      [CHANNELS-1:0]   tx_line_pos,
	output logic      [CHANNELS-1:0]   tx_line_neg,
	// Line side, from clock recovery
	input  wire logic [CHANNELS-1:0]   rx_line_clock,
	input  wire logic [CHANNELS-1:0]   rx_line_pos,
	input  wire logic [CHANNELS-1:0]   rx_line_neg
);

	initial begin
		if (CHANNELS < 1 || CHANNELS > 16)
			$error("CHANNELS must be 1 to 16");
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	cjf_ctrl_t         ctrl_r [CHANNELS];
	logic [2:0]        stat   [CHANNELS];
	logic [CHANNELS-1:0] limit_rd;
	logic              wait_r;
	logic              accept;
	logic [31:0]       rd_mux;

	assign accept = (avs_read || avs_write) && !wait_r;

	always_comb begin
		rd_mux   = 32'h0;
		limit_rd = '0;
		for (int c = 0; c < CHANNELS; c++) begin
			if (avs_address == `CJF_CTRL_BASE + 8'(4 * c))
				rd_mux = {24'h0, ctrl_r[c]};
			if (avs_address == `CJF_STAT_BASE + 8'(4 * c)) begin
				rd_mux = {29'h0, stat[c]};
				limit_rd[c] = accept && avs_read;
			end
		end
	end

	// One wait cycle, then the answer stands for the accepting edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wait_r       <= 1'b1;
			avs_readdata <= 32'h0;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r       <= 1'b0;
			avs_readdata <= avs_read ? rd_mux : 32'h0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	assign avs_waitrequest = wait_r;

	always_ff @(posedge sys_clk) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (rst)
				ctrl_r[c] <= `CJF_CTRL_RESET;
			else if (accept && avs_write && avs_byteenable[0]
				&& avs_address == `CJF_CTRL_BASE + 8'(4 * c))
				ctrl_r[c] <= avs_writedata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Per-channel datapath
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		cjf_ctrl_t  cr;
		cjf_lb_t    lb;
		logic [2:0] s_tc, s_tp, s_tn, s_rc, s_rp, s_rn;
		logic       l_tc, l_tp, l_tn, l_rc, l_rp, l_rn;
		logic       tx_ev, rx_pin_ev;
		logic       ja_bypass, ja_deep;
		logic       rx_in_ev, tx_in_ev, ja_in_ev, ja_out_ev;
		logic       rx_st_ev, tx_st_ev;
		cjf_rail_t  rx_in_d, tx_in_d, ja_in_d, ja_out_d;
		cjf_rail_t  rx_st_d, tx_st_d;

		assign cr = ctrl_r[ch];
		// Select decoding: a=remote, b=analog, both=digital
		assign lb = cjf_lb_t'({cr.loop_a, cr.loop_b});

		// Three-stage synchronisers; a level counts when stage 2 and 3 agree
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				{s_tc, s_tp, s_tn, s_rc, s_rp, s_rn} <= '0;
				{l_tc, l_tp, l_tn, l_rc, l_rp, l_rn} <= '0;
			end else begin
				s_tc <= {s_tc[1:0], line_transmit_clock[ch]};
				s_tp <= {s_tp[1:0], transmit_positive_data[ch]};
				s_tn <= {s_tn[1:0], transmit_negative_data[ch]};
				s_rc <= {s_rc[1:0], rx_line_clock[ch]};
				s_rp <= {s_rp[1:0], rx_line_pos[ch]};
				s_rn <= {s_rn[1:0], rx_line_neg[ch]};
				if (s_tc[1] == s_tc[2]) l_tc <= s_tc[2];
				if (s_tp[1] == s_tp[2]) l_tp <= s_tp[2];
				if (s_tn[1] == s_tn[2]) l_tn <= s_tn[2];
				if (s_rc[1] == s_rc[2]) l_rc <= s_rc[2];
				if (s_rp[1] == s_rp[2]) l_rp <= s_rp[2];
				if (s_rn[1] == s_rn[2]) l_rn <= s_rn[2];
			end
		end

		assign tx_ev     = s_tc[1] && s_tc[2] && !l_tc;
		assign rx_pin_ev = s_rc[1] && s_rc[2] && !l_rc;

		// ------------------------------------------------------------
		// Pattern generator with single error insertion
		// ------------------------------------------------------------
		logic [22:0] gen_r;
		logic        gen_fb;
		logic        ins_prev_r, ins_pend_r;

		// Standard taps: x^23+x^18+1 and x^15+x^14+1
		assign gen_fb = cr.rate_e3
			? gen_r[22] ^ gen_r[`CJF_PRBS23_TAP]
			: gen_r[14] ^ gen_r[`CJF_PRBS15_TAP];

		always_ff @(posedge sys_clk) begin
			if (rst || !cr.pattern_enable)
				gen_r <= 23'h7FFFFF;
			else if (tx_ev && lb != CJF_LB_REMOTE)
				gen_r <= {gen_r[21:0], gen_fb};
		end

		// Only a fresh zero-to-one write arms an error
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				ins_prev_r <= 1'b0;
				ins_pend_r <= 1'b0;
			end else begin
				ins_prev_r <= cr.err_insert;
				if (cr.pattern_enable && cr.err_insert && !ins_prev_r)
					ins_pend_r <= 1'b1;
				else if (tx_ev && lb != CJF_LB_REMOTE || !cr.pattern_enable)
					ins_pend_r <= 1'b0;
			end
		end

		// ------------------------------------------------------------
		// Stream selection around the attenuator
		// ------------------------------------------------------------
		logic      tl_ev_r;
		cjf_rail_t tl_d_r;

		always_comb begin
			// Analog loopback feeds the line output back in
			if (lb == CJF_LB_ANALOG) begin
				rx_in_ev = tl_ev_r;
				rx_in_d  = tl_d_r;
			end else begin
				rx_in_ev = rx_pin_ev;
				rx_in_d  = '{pos: l_rp, neg: l_rn};
			end
			rx_st_ev = (!ja_bypass && !cr.path_tx) ? ja_out_ev : rx_in_ev;
			rx_st_d  = (!ja_bypass && !cr.path_tx) ? ja_out_d  : rx_in_d;
			// Remote loopback ignores transmit pins
			if (lb == CJF_LB_REMOTE) begin
				tx_in_ev = rx_st_ev;
				tx_in_d  = rx_st_d;
			end else if (cr.pattern_enable) begin
				tx_in_ev = tx_ev;
				tx_in_d  = '{pos: gen_fb ^ ins_pend_r, neg: 1'b0};
			end else begin
				tx_in_ev = tx_ev;
				tx_in_d  = '{pos: l_tp, neg: l_tn};
			end
			ja_in_ev = cr.path_tx ? tx_in_ev : rx_in_ev;
			ja_in_d  = cr.path_tx ? tx_in_d  : rx_in_d;
			tx_st_ev = (!ja_bypass && cr.path_tx) ? ja_out_ev : tx_in_ev;
			tx_st_d  = (!ja_bypass && cr.path_tx) ? ja_out_d  : tx_in_d;
		end

		// ------------------------------------------------------------
		// Jitter attenuator FIFO and smoothed read clock
		// ------------------------------------------------------------
		cjf_rail_t  mem [`CJF_FIFO_MAX];
		logic [5:0] wptr_r, rptr_r, fill, depth;
		logic       run_r, lim_r, near;
		logic [7:0] per_cnt_r, rd_cnt_r, rd_per;
		logic [11:0] avg_r;

		// 00 and 11 bypass, 01 shallow, 10 deep
		assign ja_bypass = cr.cfg_bit0 == cr.cfg_bit1;
		assign ja_deep   = cr.cfg_bit1;
		assign depth     = ja_deep ? 6'd32 : 6'd16;
		assign fill      = wptr_r - rptr_r;
		assign near      = fill <= 6'(`CJF_LIMIT_GAP)
			|| fill >= depth - 6'(`CJF_LIMIT_GAP);
		// Read period tracks the averaged write period, nudged by fill
		always_comb begin
			rd_per = avg_r[11:4];
			if (fill > (depth >> 1))
				rd_per = avg_r[11:4] - 8'h01;
			else if (fill < (depth >> 1))
				rd_per = avg_r[11:4] + 8'h01;
		end
		assign ja_out_ev = run_r && rd_cnt_r >= rd_per && fill != 6'h00;
		assign ja_out_d  = mem[rptr_r[4:0]];

		always_ff @(posedge sys_clk) begin
			if (ja_in_ev && !ja_bypass && fill < depth)
				mem[wptr_r[4:0]] <= ja_in_d;
		end

		// Reading the flag empties the FIFO and restarts centring
		always_ff @(posedge sys_clk) begin
			if (rst || ja_bypass || limit_rd[ch]) begin
				wptr_r <= 6'h00;
				rptr_r <= 6'h00;
				run_r  <= 1'b0;
			end else begin
				if (ja_in_ev && fill < depth)
					wptr_r <= wptr_r + 6'h01;
				if (ja_out_ev)
					rptr_r <= rptr_r + 6'h01;
				if (fill >= (depth >> 1))
					run_r <= 1'b1;
			end
		end

		// Internal smoothed clock, no reference needed
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				per_cnt_r <= 8'h00;
				rd_cnt_r  <= 8'h00;
				avg_r     <= 12'h080;
			end else begin
				per_cnt_r <= ja_in_ev ? 8'h01
					: (per_cnt_r == 8'hFF ? per_cnt_r : per_cnt_r + 8'h01);
				if (ja_in_ev)
					avg_r <= avg_r
						+ 12'($signed({per_cnt_r, 4'h0} - avg_r) >>> 3);
				rd_cnt_r <= ja_out_ev || !run_r ? 8'h01
					: (rd_cnt_r == 8'hFF ? rd_cnt_r : rd_cnt_r + 8'h01);
			end
		end

		// Set wins over the clearing read
		always_ff @(posedge sys_clk) begin
			if (rst)
				lim_r <= 1'b0;
			else if (run_r && near && !ja_bypass)
				lim_r <= 1'b1;
			else if (limit_rd[ch])
				lim_r <= 1'b0;
		end

		// ------------------------------------------------------------
		// Pattern checker
		// ------------------------------------------------------------
		logic [22:0] chk_r;
		logic        chk_err;
		cjf_chk_t    chk_st;
		logic [5:0]  good_r;
		logic [2:0]  bad_r;

		assign chk_err = rx_st_d.pos ^ (cr.rate_e3
			? chk_r[22] ^ chk_r[`CJF_PRBS23_TAP]
			: chk_r[14] ^ chk_r[`CJF_PRBS15_TAP]);

		// Checker shares the generator's enable bit
		always_ff @(posedge sys_clk) begin
			if (rst || !cr.pattern_enable) begin
				chk_r  <= 23'h0;
				chk_st <= CJF_HUNT;
				good_r <= 6'h00;
				bad_r  <= 3'h0;
			end else if (rx_st_ev) begin
				chk_r  <= {chk_r[21:0], rx_st_d.pos};
				good_r <= chk_err ? 6'h00 : good_r + 6'h01;
				unique case (chk_st)
					CJF_HUNT: begin
						bad_r <= 3'h0;
						if (!chk_err && good_r == 6'(`CJF_SYNC_GOOD - 1))
							chk_st <= CJF_LOCK;
					end
					CJF_LOCK: begin
						if (chk_err && bad_r == 3'(`CJF_LOSS_ERR - 1))
							chk_st <= CJF_HUNT;
						else if (chk_err)
							bad_r <= bad_r + 3'h1;
						else if (good_r == 6'h3F)
							bad_r <= 3'h0;
					end
				endcase
			end
		end

		assign stat[ch] = {run_r,
			cr.pattern_enable && chk_st == CJF_HUNT, lim_r};

		// ------------------------------------------------------------
		// Output retiming and clock shaping
		// ------------------------------------------------------------
		logic [1:0] rx_lo_r, tx_lo_r;

		always_ff @(posedge sys_clk) begin
			if (rst) begin
				line_receive_clock[ch]    <= 1'b0;
				receive_positive_data[ch] <= 1'b0;
				rx_neg_violation_out[ch]  <= 1'b0;
				rx_lo_r                   <= 2'h0;
			end else if (lb == CJF_LB_DIGITAL) begin
				line_receive_clock[ch]    <= l_tc;
				receive_positive_data[ch] <= l_tp;
				rx_neg_violation_out[ch]  <= l_tn;
			end else if (rx_st_ev) begin
				line_receive_clock[ch]    <= 1'b0;
				rx_lo_r                   <= 2'(`CJF_CLK_LOW);
				receive_positive_data[ch] <= rx_st_d.pos;
				if (!cr.pattern_enable)
					rx_neg_violation_out[ch] <= rx_st_d.neg;
				else if (chk_st == CJF_HUNT)
					rx_neg_violation_out[ch] <= 1'b1;
				else
					rx_neg_violation_out[ch] <= chk_err;
			end else if (rx_lo_r != 2'h0) begin
				rx_lo_r <= rx_lo_r - 2'h1;
				if (rx_lo_r == 2'h1)
					line_receive_clock[ch] <= 1'b1;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (rst) begin
				tx_line_clock[ch] <= 1'b0;
				tx_line_pos[ch]   <= 1'b0;
				tx_line_neg[ch]   <= 1'b0;
				tl_ev_r           <= 1'b0;
				tl_d_r            <= '0;
				tx_lo_r           <= 2'h0;
			end else begin
				tl_ev_r <= tx_st_ev;
				if (tx_st_ev) begin
					tl_d_r            <= tx_st_d;
					tx_line_clock[ch] <= 1'b0;
					tx_lo_r           <= 2'(`CJF_CLK_LOW);
					tx_line_pos[ch]   <= tx_st_d.pos;
					tx_line_neg[ch]   <= tx_st_d.neg;
				end else if (tx_lo_r != 2'h0) begin
					tx_lo_r <= tx_lo_r - 2'h1;
					if (tx_lo_r == 2'h1)
						tx_line_clock[ch] <= 1'b1;
				end
			end
		end
	end

endmodule : cjf_channel
`default_nettype wire

// ### tb/cjf_assertions.sv
// Port-level checker for the channel block
`timescale 1ns/10ps
`default_nettype none
module cjf_chk
	import cjf_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clock, reset and register bus
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic [7:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [3:0]          avs_byteenable,
	input wire logic [31:0]         avs_writedata,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest,
	// Streams
	input wire logic [CHANNELS-1:0] line_transmit_clock,
	input wire logic [CHANNELS-1:0] line_receive_clock,
	input wire logic [CHANNELS-1:0] tx_line_clock,
	input wire logic [CHANNELS-1:0] tx_line_neg
);
	// ----
	// Shadow of channel 0 control and time since it was last written
	// ----
	logic [7:0] sh_r;
	logic [5:0] age_r;
	wire logic  acc = !avs_waitrequest && (avs_address == 8'h00);

	always_ff @(posedge sys_clk) begin
		if (rst)
			sh_r <= 8'h00;
		else if (acc && avs_write && avs_byteenable[0])
			sh_r <= avs_writedata[7:0];
	end

	// Modes are judged only once settled, long after a control write
	always_ff @(posedge sys_clk) begin
		if (rst || (acc && avs_write))
			age_r <= 6'h00;
		else if (age_r != 6'h3F)
			age_r <= age_r + 6'h01;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_tx_follow;
		##[3:9] $rose(tx_line_clock[0]);
	endsequence

	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer not after one wait");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
		else $error("waitrequest low with no request");
	a_ctrl_read: assert property (acc && avs_read
		|-> avs_readdata == {24'h000000, sh_r}) else $error("control readback");
	a_unmapped_zero: assert property (!avs_waitrequest && avs_read
		&& avs_address[7] |-> avs_readdata == 32'h0) else $error("unmapped read");
	a_single_rail: assert property (sh_r[3] && age_r == 6'h3F
		|-> !tx_line_neg[0]) else $error("negative rail active in pattern mode");
	a_digital_clock: assert property (sh_r[6:5] == 2'b11 && age_r == 6'h3F
		&& $rose(line_transmit_clock[0]) |-> ##[2:8] line_receive_clock[0])
		else $error("looped clock missing");
	a_normal_tx: assert property (sh_r[6:1] == 6'h00 && age_r == 6'h3F
		&& $rose(line_transmit_clock[0]) |-> s_tx_follow)
		else $error("transmit stream not following");
	a_rx_clk_low: assert property ($fell(line_receive_clock[0])
		|=> !line_receive_clock[0]) else $error("receive clock low too short");
endmodule : cjf_chk

bind cjf_channel cjf_chk #(.CHANNELS(CHANNELS)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.line_transmit_clock(line_transmit_clock),
	.line_receive_clock(line_receive_clock),
	.tx_line_clock(tx_line_clock), .tx_line_neg(tx_line_neg)
);
`default_nettype wire

// ### tb/cjf_framer.sv
// Framer model: one rail pair and the link clock that times it
`timescale 1ns/10ps
`default_nettype none
module cjf_framer (
	// From the bench
	input wire logic run,
	input wire logic pos_lvl,
	input wire logic neg_lvl,
	// Toward the block
	output logic     clk_o,
	output logic     pos_o,
	output logic     neg_o
);
	initial begin
		clk_o = 1'b0;
		pos_o = 1'b0;
		neg_o = 1'b0;
	end
	// Clock stands low outside frames
	always #80 clk_o = run ? ~clk_o : 1'b0;
	// Data moves on the fall so it is settled before the rise
	always @(negedge clk_o) begin
		pos_o <= pos_lvl;
		neg_o <= neg_lvl;
	end
endmodule : cjf_framer
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the channel block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [31:0] rdat;
	logic        avs_waitrequest;
	logic        tx_run = 1'b0, tx_p = 1'b0, tx_n = 1'b0;
	logic        rx_run = 1'b0, rx_p = 1'b0, rx_n = 1'b0;
	logic        ltc, tpd, tnd, lrc, rpd, rnv, tlc, tlp, tln, rlc, rlp, rln;
	int          num_errors = 0;
	int          samples_checked = 0;

	always #10 sys_clk = ~sys_clk;

	cjf_framer fr_tx (.run(tx_run), .pos_lvl(tx_p), .neg_lvl(tx_n),
		.clk_o(ltc), .pos_o(tpd), .neg_o(tnd));
	cjf_framer fr_rx (.run(rx_run), .pos_lvl(rx_p), .neg_lvl(rx_n),
		.clk_o(rlc), .pos_o(rlp), .neg_o(rln));
	cjf_channel #(.CHANNELS(1)) dut (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.line_transmit_clock(ltc), .transmit_positive_data(tpd),
		.transmit_negative_data(tnd), .line_receive_clock(lrc),
		.receive_positive_data(rpd), .rx_neg_violation_out(rnv),
		.tx_line_clock(tlc), .tx_line_pos(tlp), .tx_line_neg(tln),
		.rx_line_clock(rlc), .rx_line_pos(rlp), .rx_line_neg(rln));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input string what, input logic [31:0] seen, want);
		samples_checked++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle

	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be = 4'hF);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 40)
			num_errors++;
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic pulses(output int n);
		logic prev;
		prev = rnv;
		n = 0;
		repeat (400) begin
			@(posedge sys_clk);
			if (rnv === 1'b1 && prev !== 1'b1)
				n++;
			prev = rnv;
		end
	endtask : pulses

	task automatic poly(input int a, input int b);
		logic [47:0] s;
		int bad;
		bad = 0;
		for (int i = 0; i < 48; i++) begin
			@(posedge tlc);
			s[i] = tlp;
		end
		for (int i = a; i < 48; i++)
			if (s[i] !== (s[i-a] ^ s[i-b]))
				bad++;
		chk("pattern taps", bad, 0);
		chk("pattern live", |s, 1'b1);
		@(posedge sys_clk);
	endtask : poly

	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		bus(1'b1, 8'h00, 32'hFFFF_FF67);
		bus(1'b1, 8'h00, 32'h0, 4'hE);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl", rdat, 32'h0000_0067);
		bus(1'b0, 8'h80, 32'h0);
		chk("unmapped", rdat, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk("status top", rdat[31:3], 29'h0);
		bus(1'b1, 8'h00, 32'h0);
		$display("done regs");
	endtask : t_regs

	task automatic t_loops;
		bus(1'b1, 8'h00, 32'h0000_0060);
		tx_run <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			tx_p <= !i[0];
			tx_n <= i[0];
			idle(200);
			chk("loop pos", rpd, !i[0]);
			chk("loop neg", rnv, i[0]);
		end
		tx_p <= 1'b1;
		tx_n <= 1'b1;
		rx_n <= 1'b1;
		rx_run <= 1'b1;
		bus(1'b1, 8'h00, 32'h0);
		idle(200);
		chk("tx pos", tlp, 1'b1);
		chk("tx neg", tln, 1'b1);
		chk("rx pos", rpd, 1'b0);
		chk("rx neg", rnv, 1'b1);
		bus(1'b1, 8'h00, 32'h0000_0020);
		idle(200);
		chk("remote tx", tlp, 1'b0);
		chk("remote rx", rpd, 1'b0);
		bus(1'b1, 8'h00, 32'h0);
		$display("done loopbacks");
	endtask : t_loops

	task automatic t_fifo(input logic path, input logic [1:0] cfg);
		tx_run <= 1'b1;
		rx_run <= 1'b1;
		rx_p <= 1'b1;
		bus(1'b1, 8'h00, {29'h0, cfg, path});
		idle(600);
		bus(1'b0, 8'h40, 32'h0);
		chk("running", rdat[2], 1'b1);
		chk("fifo data", path ? tlp : rpd, 1'b1);
		// The status read emptied the FIFO; let it refill and run again
		idle(600);
		// Starving the write side drains the FIFO toward its limit
		if (path)
			tx_run <= 1'b0;
		else
			rx_run <= 1'b0;
		idle(600);
		bus(1'b0, 8'h40, 32'h0);
		chk("limit set", rdat[0], 1'b1);
		// Set wins on the clearing edge, so the flag survives one read
		bus(1'b0, 8'h40, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk("limit cleared", {rdat[2], rdat[0]}, 2'b00);
		bus(1'b1, 8'h00, 32'h0);
		$display("done fifo");
	endtask : t_fifo

	task automatic t_prbs(input logic e3);
		logic [31:0] c;
		int n;
		c = {24'h0, e3, 7'h08};
		bus(1'b1, 8'h00, c);
		idle(600);
		bus(1'b0, 8'h40, 32'h0);
		chk("sync lost", rdat[1], 1'b1);
		chk("hunt level", rnv, 1'b1);
		c = c | 32'h40;
		bus(1'b1, 8'h00, c);
		idle(800);
		bus(1'b0, 8'h40, 32'h0);
		chk("sync held", rdat[1], 1'b0);
		chk("lock level", rnv, 1'b0);
		chk("neg rail", tln, 1'b0);
		if (e3)
			poly(23, 18);
		else
			poly(15, 14);
		bus(1'b1, 8'h00, c | 32'h10);
		pulses(n);
		chk("first insert", n >= 1 && n <= 3, 1'b1);
		bus(1'b1, 8'h00, c | 32'h10);
		pulses(n);
		chk("repeat one", n, 0);
		bus(1'b1, 8'h00, c);
		bus(1'b1, 8'h00, c | 32'h10);
		pulses(n);
		chk("second insert", n >= 1 && n <= 3, 1'b1);
		bus(1'b1, 8'h00, 32'h0);
		$display("done pattern");
	endtask : t_prbs

	initial begin
		#1_000_000;
		num_errors++;
		end_sim;
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_regs;
		t_loops;
		// Shallow depth first: the low-latency setting
		for (int c = 1; c < 3; c++)
			for (int p = 0; p < 2; p++)
				t_fifo(p[0], c[1:0]);
		tx_run <= 1'b1;
		rx_run <= 1'b1;
		t_prbs(1'b0);
		t_prbs(1'b1);
		end_sim;
	end
endmodule : testbench
`default_nettype wire
